// [inc/rsf_pkg.sv]
// Shared constants and types of the core register file block
package rsf_pkg;
   localparam int REG_COUNT = 16;
   localparam int REG_WIDTH = 8;
   localparam int PC_WIDTH = 16;
   localparam int INSTR_WIDTH = 22;
   localparam int GENERIC_OPS = 35;
   localparam int ADDR_MODES = 8;
   // Register indices
   localparam logic [3:0] IDX_DATA_OFFSET = 4'h3;
   localparam logic [3:0] IDX_PROG_IDX_HI = 4'hc;
   localparam logic [3:0] IDX_PROG_IDX_LO = 4'hd;
   localparam logic [3:0] IDX_STATUS = 4'he;
   localparam logic [3:0] IDX_ACC = 4'hf;
   // Status bit positions
   localparam int ST_LEVEL2_EN = 7;
   localparam int ST_LEVEL1_EN = 6;
   localparam int ST_GLOBAL_EN = 5;
   localparam int ST_LEVEL2_REQ = 4;
   localparam int ST_LEVEL1_REQ = 3;
   localparam int ST_LEVEL0_REQ = 2;
   localparam int ST_LOW_EVT = 1;
   localparam int ST_HIGH_EVT = 0;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   // Software port offsets
   localparam logic [4:0] OFS_REG_BASE = 5'h00;
   localparam logic [4:0] OFS_FLAGS = 5'h10;
   localparam logic [4:0] OFS_PC_LO = 5'h11;
   localparam logic [4:0] OFS_PC_HI = 5'h12;
   localparam logic [4:0] OFS_INT_STATUS = 5'h13;
   localparam logic [4:0] OFS_INT_CLEAR = 5'h14;
   localparam logic [4:0] OFS_INT_ENABLE = 5'h15;
   localparam logic [4:0] OFS_CONTROL = 5'h16;
   localparam logic [7:0] CONTROL_RESET = 8'h01;
   localparam int EV_INT_TAKEN = 0;
   localparam int EV_WAKE = 1;
   localparam int EV_STACK_ERR = 2;
   // Opcodes, bits 21:16 of the instruction word
   typedef enum logic [5:0] {
      OP_NOP = 6'h00, OP_JUMP = 6'h01, OP_JUMPIP = 6'h02, OP_JCCIP = 6'h03,
      OP_CALL = 6'h04, OP_CALLIP = 6'h05, OP_CALLS = 6'h06,
      OP_CALLSIP = 6'h07,
      OP_JC = 6'h08, OP_JNC = 6'h09, OP_JZ = 6'h0a, OP_JNZ = 6'h0b,
      OP_JV = 6'h0c, OP_JNV = 6'h0d,
      OP_RET = 6'h10, OP_RETS = 6'h11, OP_RETI = 6'h12, OP_PUSH = 6'h13,
      OP_POP = 6'h14, OP_HALT = 6'h15,
      OP_MOVI = 6'h20, OP_MOVR = 6'h21, OP_CMVD = 6'h22, OP_CMVS = 6'h23,
      OP_SHL = 6'h24, OP_SHLC = 6'h25, OP_SHR = 6'h26, OP_SHRC = 6'h27,
      OP_ADD = 6'h28, OP_ADDC = 6'h29, OP_SUB = 6'h2a, OP_SUBC = 6'h2b,
      OP_AND = 6'h2c, OP_OR = 6'h2d, OP_XOR = 6'h2e, OP_MUL = 6'h2f
   } rsf_op_t;
   typedef struct packed {
      rsf_op_t op;
      logic [3:0] dst;
      logic [3:0] src;
      logic [7:0] imm;
   } rsf_instr_t;
   typedef struct packed {
      logic carry;
      logic ovf;
      logic zero;
   } rsf_flags_t;
endpackage

// [logic/rsf_core_regs.sv]
// Programmer-visible state of the 8-bit core: registers, status, PC, stack
// How it works
// - sixteen 8-bit registers: one array plus status and acc.
// - the program-index byte pair joins into a 16-bit word.
// - 22-bit instruction words decode into generic operations.
// - each accepted instruction completes in its one clock cycle.
// - halted core wakes on any pending interrupt or event request bit.
// - enabled irq wake enters service routine, any other wake resumes after halt.
// - 16-bit program counter holds address of next instruction.
// - return stack saves return address on CALL, CALLIP and interrupt entry.
// - roles: general, offset, index pairs, program index, status, acc.
// - status bits 7 and 6 enable level-2 and level-1 interrupts.
// - status bit 5 is the global interrupt enable.
// - status bits 4..2 hold level 2, 1, 0 interrupt requests.
// - status bits 1 and 0 hold low and high event requests.
// - zero flag is one exactly when the accumulator is zero.
// - shift puts the bit shifted out into carry.
// - carry set on add overflow, cleared on subtract underflow.
// - overflow flag set on signed overflow of arithmetic or shift.
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
module rsf_core_regs
   import rsf_pkg::*;
#(
   parameter int STACK_DEPTH = 8,
   parameter logic [15:0] LEVEL0_VECTOR = 16'h0001,
   parameter logic [15:0] LEVEL1_VECTOR = 16'h0002,
   parameter logic [15:0] LEVEL2_VECTOR = 16'h0003
) (
   input logic core_clk, // Core clock
   input logic arst_n, // Asynchronous reset, active low
   input logic [21:0] instrWord, // Instruction at pcAddr
   input logic instrValid, // Instruction word present
   output logic [15:0] pcAddr, // Program counter, fetch address
   output logic halted, // Core stopped by halt
   input logic [2:0] irqReq, // Interrupt pulses, bit n is level n
   input logic [1:0] evtReq, // Event pulses, bit1 low, bit0 high
   input logic [4:0] regAddr, // Software port address
   input logic [7:0] regWdata, // Software write data
   input logic regWr, // Software write strobe
   input logic regRd, // Software read strobe
   output logic [7:0] regRdata, // Read data, cycle after regRd
   output logic irqOut // Block interrupt, level
);
   typedef enum logic [1:0] {
      S_RUN = 2'b01,
      S_HALT = 2'b10
   } rsf_state_t;

   localparam int SP_W = $clog2(STACK_DEPTH + 1);

   rsf_state_t state_r;
   rsf_state_t state_nxt;
   logic [7:0] regs_r [0:13];
   logic [7:0] stat_r;
   logic [7:0] statNxt;
   logic [7:0] acc_r;
   logic [15:0] pc_r;
   logic carry_r;
   logic ovf_r;
   logic [15:0] stk_r [0:STACK_DEPTH-1];
   logic [SP_W-1:0] stkCnt_r;
   logic [2:0] intSts_r;
   logic [2:0] intEn_r;
   logic [7:0] ctrl_r;
   logic [7:0] rdata_r;
   rsf_flags_t flags;

   function automatic logic [7:0] rdReg(input logic [3:0] idx,
                                        input logic [7:0] stat,
                                        input logic [7:0] acc,
                                        input logic [7:0] gp);
      logic [7:0] v;
      v = gp;
      if (idx == IDX_STATUS) begin
         v = stat;
      end else if (idx == IDX_ACC) begin
         v = acc;
      end
      return v;
   endfunction

   // Decode
   rsf_instr_t ins;
   wire [15:0] insAddr = instrWord[15:0];
   assign ins = rsf_instr_t'(instrWord);
   wire [7:0] dstVal = rdReg(ins.dst, stat_r, acc_r,
                             regs_r[ins.dst > 4'hd ? 4'h0 : ins.dst]);
   wire [7:0] srcVal = rdReg(ins.src, stat_r, acc_r,
                             regs_r[ins.src > 4'hd ? 4'h0 : ins.src]);
   wire [15:0] progIdx = {regs_r[IDX_PROG_IDX_HI],
                          regs_r[IDX_PROG_IDX_LO]};
   wire [15:0] pcInc = pc_r + 16'h0001;
   assign flags = {carry_r, ovf_r, (acc_r == 8'h00)};

   // Interrupt acceptance, level 0 highest
   wire gEn = stat_r[ST_GLOBAL_EN];
   wire lv0 = gEn & stat_r[ST_LEVEL0_REQ];
   wire lv1 = gEn & stat_r[ST_LEVEL1_EN] &
              stat_r[ST_LEVEL1_REQ];
   wire lv2 = gEn & stat_r[ST_LEVEL2_EN] &
              stat_r[ST_LEVEL2_REQ];
   wire running = ctrl_r[0];
   wire anyReq = |stat_r[ST_LEVEL2_REQ:ST_HIGH_EVT];
   wire wake = (state_r == S_HALT) & anyReq;
   wire takeIrq = running & (lv0 | lv1 | lv2);
   wire [15:0] vec = lv0 ? LEVEL0_VECTOR :
                     (lv1 ? LEVEL1_VECTOR : LEVEL2_VECTOR);
   wire exec = running & (state_r == S_RUN) & instrValid & ~takeIrq;
   wire stkFull = (stkCnt_r == SP_W'(STACK_DEPTH));
   wire stkEmpty = (stkCnt_r == '0);

   // Execution results
   logic [15:0] pcNxt;
   logic wrEn;
   logic [3:0] wrIdx;
   logic [7:0] wrVal;
   logic accEn;
   logic [7:0] accVal;
   logic ipEn;
   logic [15:0] ipVal;
   logic push;
   logic [15:0] pushVal;
   logic pop;
   logic cNxt;
   logic vNxt;
   logic goHalt;
   logic retiSet;
   logic [8:0] sum;
   logic [15:0] prod;
   logic jmpOk;

   always_comb begin
      pcNxt = pcInc;
      wrEn = 1'b0;
      wrIdx = ins.dst;
      wrVal = 8'h00;
      accEn = 1'b0;
      accVal = 8'h00;
      ipEn = 1'b0;
      ipVal = pcInc;
      push = 1'b0;
      pushVal = pcInc;
      pop = 1'b0;
      cNxt = carry_r;
      vNxt = ovf_r;
      goHalt = 1'b0;
      retiSet = 1'b0;
      sum = 9'h000;
      prod = 16'h0000;
      jmpOk = 1'b0;
      case (ins.op)
         OP_JUMP: pcNxt = insAddr;
         OP_JUMPIP: pcNxt = progIdx;
         OP_JC, OP_JNC, OP_JZ, OP_JNZ, OP_JV, OP_JNV, OP_JCCIP: begin
            case (ins.op == OP_JCCIP ? ins.imm[2:0] : ins.op[2:0])
               3'h0: jmpOk = flags.carry;
               3'h1: jmpOk = ~flags.carry;
               3'h2: jmpOk = flags.zero;
               3'h3: jmpOk = ~flags.zero;
               3'h4: jmpOk = flags.ovf;
               3'h5: jmpOk = ~flags.ovf;
               default: jmpOk = 1'b0;
            endcase
            if (jmpOk) begin
               pcNxt = (ins.op == OP_JCCIP) ? progIdx : insAddr;
            end
         end
         OP_CALL, OP_CALLIP: begin
            push = 1'b1;
            pcNxt = (ins.op == OP_CALL) ? insAddr : progIdx;
         end
         OP_CALLS, OP_CALLSIP: begin
            ipEn = 1'b1;
            pcNxt = (ins.op == OP_CALLS) ? insAddr : progIdx;
         end
         OP_RET, OP_RETI: begin
            pop = 1'b1;
            pcNxt = stk_r[0];
            retiSet = (ins.op == OP_RETI);
         end
         OP_RETS: pcNxt = progIdx;
         OP_PUSH: begin
            push = 1'b1;
            pushVal = progIdx;
         end
         OP_POP: begin
            pop = 1'b1;
            ipEn = 1'b1;
            ipVal = stk_r[0];
         end
         OP_HALT: goHalt = 1'b1;
         OP_MOVI, OP_MOVR: begin
            accVal = (ins.op == OP_MOVI) ? ins.imm : srcVal;
            accEn = 1'b1;
            wrEn = 1'b1;
            wrVal = accVal;
         end
         OP_CMVD, OP_CMVS: begin
            accVal = srcVal;
            accEn = 1'b1;
            wrEn = (ins.op == OP_CMVS) ? carry_r : ~carry_r;
            wrVal = srcVal;
         end
         OP_SHL, OP_SHLC: begin
            accVal = {srcVal[6:0], (ins.op == OP_SHLC) & carry_r};
            cNxt = srcVal[7];
            vNxt = srcVal[7] ^ srcVal[6];
         end
         OP_SHR, OP_SHRC: begin
            accVal = {(ins.op == OP_SHRC) & carry_r, srcVal[7:1]};
            cNxt = srcVal[0];
            vNxt = accVal[7] ^ srcVal[7];
         end
         OP_ADD, OP_ADDC: begin
            sum = {1'b0, dstVal} + {1'b0, srcVal} +
                  {8'h00, (ins.op == OP_ADDC) & carry_r};
            accVal = sum[7:0];
            cNxt = sum[8];
            vNxt = (dstVal[7] == srcVal[7]) &
                   (sum[7] != dstVal[7]);
         end
         OP_SUB, OP_SUBC: begin
            // Borrow-inverted carry: carry in of one means no borrow
            sum = {1'b0, dstVal} + {1'b0, ~srcVal} +
                  {8'h00, (ins.op == OP_SUB) | carry_r};
            accVal = sum[7:0];
            cNxt = sum[8];
            vNxt = (dstVal[7] != srcVal[7]) &
                   (sum[7] != dstVal[7]);
         end
         OP_AND: accVal = dstVal & srcVal;
         OP_OR: accVal = dstVal | srcVal;
         OP_XOR: accVal = dstVal ^ srcVal;
         OP_MUL: begin
            prod = dstVal * srcVal;
            accVal = prod[7:0];
            accEn = 1'b1;
            wrEn = 1'b1;
            wrVal = prod[15:8];
         end
         default: pcNxt = pcInc;
      endcase
      if ((ins.op >= OP_SHL && ins.op <= OP_XOR)) begin
         accEn = 1'b1;
         wrEn = 1'b1;
         wrVal = accVal;
      end
   end

   // Software port decode
   wire busRegWr = regWr & (regAddr[4] == 1'b0);
   wire [3:0] busIdx = regAddr[3:0];
   wire statWrCore = exec & wrEn & (wrIdx == IDX_STATUS);
   wire statWrBus = busRegWr & (busIdx == IDX_STATUS);
   wire clrWr = regWr & (regAddr == OFS_INT_CLEAR);
   wire [2:0] intEv;
   assign intEv[EV_INT_TAKEN] = takeIrq;
   assign intEv[EV_WAKE] = wake;
   assign intEv[EV_STACK_ERR] = (exec & push & stkFull) |
                                (exec & pop & stkEmpty);
   assign irqOut = |(intSts_r & intEn_r);

   always_comb begin
      statNxt = stat_r;
      if (statWrBus) begin
         statNxt = regWdata;
      end
      if (statWrCore) begin
         statNxt = wrVal;
      end
      if (exec & retiSet) begin
         statNxt[ST_GLOBAL_EN] = 1'b1;
      end
      if (takeIrq) begin
         statNxt[ST_GLOBAL_EN] = 1'b0;
      end
      // Request set wins over a clear in the same cycle
      statNxt[ST_LEVEL2_REQ:ST_LEVEL0_REQ] =
         statNxt[ST_LEVEL2_REQ:ST_LEVEL0_REQ] | irqReq;
      statNxt[ST_LOW_EVT:ST_HIGH_EVT] =
         statNxt[ST_LOW_EVT:ST_HIGH_EVT] | evtReq;
   end

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         S_RUN: if (exec & goHalt) state_nxt = S_HALT;
         S_HALT: if (wake) state_nxt = S_RUN;
         default: state_nxt = S_RUN;
      endcase
   end

   wire [7:0] rdMux =
      (regAddr[4] == 1'b0) ?
         rdReg(busIdx, stat_r, acc_r,
               regs_r[busIdx > 4'hd ? 4'h0 : busIdx]) :
      (regAddr == OFS_FLAGS) ? {5'h00, flags.ovf, flags.carry, flags.zero} :
      (regAddr == OFS_PC_LO) ? pc_r[7:0] :
      (regAddr == OFS_PC_HI) ? pc_r[15:8] :
      (regAddr == OFS_INT_STATUS) ? {5'h00, intSts_r} :
      (regAddr == OFS_INT_ENABLE) ? {5'h00, intEn_r} :
      (regAddr == OFS_CONTROL) ? ctrl_r : 8'h00;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= S_RUN;
         pc_r <= 16'h0000;
         stat_r <= STATUS_RESET;
         carry_r <= 1'b0;
         ovf_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         stat_r <= statNxt;
         if (takeIrq) begin
            pc_r <= vec;
         end else if (exec) begin
            pc_r <= pcNxt;
            carry_r <= cNxt;
            ovf_r <= vNxt;
         end
      end
   end

   // General registers and accumulator; core write beats software write
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         acc_r <= 8'h00;
         for (int i = 0; i < 14; i++) begin
            regs_r[i] <= 8'h00;
         end
      end else begin
         if (busRegWr & (busIdx == IDX_ACC)) begin
            acc_r <= regWdata;
         end else if (busRegWr & (busIdx < IDX_STATUS)) begin
            regs_r[busIdx] <= regWdata;
         end
         if (exec & accEn) begin
            acc_r <= accVal;
         end
         if (exec & wrEn & (wrIdx < IDX_STATUS)) begin
            regs_r[wrIdx] <= wrVal;
         end
         if (exec & ipEn) begin
            regs_r[IDX_PROG_IDX_HI] <= ipVal[15:8];
            regs_r[IDX_PROG_IDX_LO] <= ipVal[7:0];
         end
      end
   end

   // Return stack; oldest entry drops off when full
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         stkCnt_r <= '0;
         for (int i = 0; i < STACK_DEPTH; i++) begin
            stk_r[i] <= 16'h0000;
         end
      end else if (takeIrq | (exec & push)) begin
         stk_r[0] <= takeIrq ? pc_r : pushVal;
         for (int i = 1; i < STACK_DEPTH; i++) begin
            stk_r[i] <= stk_r[i-1];
         end
         if (!stkFull) begin
            stkCnt_r <= stkCnt_r + SP_W'(1);
         end
      end else if (exec & pop) begin
         for (int i = 0; i < STACK_DEPTH - 1; i++) begin
            stk_r[i] <= stk_r[i+1];
         end
         stk_r[STACK_DEPTH-1] <= 16'h0000;
         if (!stkEmpty) begin
            stkCnt_r <= stkCnt_r - SP_W'(1);
         end
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         intSts_r <= 3'h0;
         intEn_r <= 3'h0;
         ctrl_r <= CONTROL_RESET;
         rdata_r <= 8'h00;
      end else begin
         // Event set wins over a clear in the same cycle
         intSts_r <= (intSts_r & ~(clrWr ? regWdata[2:0] : 3'h0)) | intEv;
         if (regWr & (regAddr == OFS_INT_ENABLE)) begin
            intEn_r <= regWdata[2:0];
         end
         if (regWr & (regAddr == OFS_CONTROL)) begin
            ctrl_r <= {7'h00, regWdata[0]};
         end
         rdata_r <= regRd ? rdMux : 8'h00;
      end
   end

   assign regRdata = rdata_r;
   assign pcAddr = pc_r;
   assign halted = (state_r == S_HALT);
endmodule

// [sim/rsf_core_regs_checker.sv]
// Port-level assertions for the core register file
module rsf_core_regs_checker
   import rsf_pkg::*;
#(
   parameter logic [15:0] LEVEL0_VECTOR = 16'h0001,
   parameter logic [15:0] LEVEL1_VECTOR = 16'h0002,
   parameter logic [15:0] LEVEL2_VECTOR = 16'h0003
) (
   input logic core_clk, // Core clock
   input logic arst_n, // Reset, active low
   input logic [21:0] instrWord, // Instruction word
   input logic instrValid, // Instruction present
   input logic [15:0] pcAddr, // Program counter
   input logic halted, // Halt state
   input logic [2:0] irqReq, // Interrupt pulses
   input logic [1:0] evtReq, // Event pulses
   input logic [4:0] regAddr, // Port address
   input logic [7:0] regWdata, // Port write data
   input logic regWr, // Write strobe
   input logic regRd, // Read strobe
   input logic [7:0] regRdata, // Read data
   input logic irqOut // Block interrupt
);
   timeunit 1ns;
   timeprecision 1ps;
   logic runEn_r;
   wire execOk = instrValid && !halted && runEn_r;
   wire [5:0] opc = instrWord[21:16];
   wire atVec = pcAddr == LEVEL0_VECTOR || pcAddr == LEVEL1_VECTOR
      || pcAddr == LEVEL2_VECTOR;
   wire quiet = irqReq == 3'h0 && evtReq == 2'h0 && !regWr;
   // Software may stop the core; its instructions are then ignored
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) runEn_r <= 1'b1;
      else if (regWr && regAddr == OFS_CONTROL) runEn_r <= regWdata[0];
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   property p_movi_pc;
      execOk && opc == OP_MOVI |=> atVec || pcAddr == $past(pcAddr) + 16'h1;
   endproperty
   a_movi_pc: assert property (p_movi_pc)
      else $error("pc no step");
   property p_jump;
      execOk && opc == OP_JUMP |=> atVec || pcAddr == $past(instrWord[15:0]);
   endproperty
   a_jump: assert property (p_jump) else $error("jump missed");
   property p_halt_go;
      execOk && opc == OP_HALT |=> halted || atVec;
   endproperty
   a_halt_go: assert property (p_halt_go) else $error("no halt");
   property p_halt_hold;
      (halted && quiet) ##1 (halted && quiet) |=> halted;
   endproperty
   a_halt_hold: assert property (p_halt_hold) else $error("woke");
   property p_wake;
      halted && evtReq != 2'h0 |-> ##[1:3] !halted;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake");
   property p_resume;
      halted ##1 (!halted && !atVec) |-> pcAddr == $past(pcAddr);
   endproperty
   a_resume: assert property (p_resume)
      else $error("bad resume");
   property p_rdata_idle;
      !regRd |=> regRdata == 8'h00;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("rdata");
   property p_zero;
      (execOk && opc == OP_MOVI) ##1 !instrValid ##1 (regRd && !instrValid
         && regAddr == OFS_FLAGS && pcAddr == $past(pcAddr, 2) + 16'h1)
         |=> regRdata[0] == ($past(instrWord[7:0], 3) == 8'h00);
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag");
   property p_stack;
      (execOk && opc == OP_CALL) ##1 !instrValid ##1 (execOk
         && opc == OP_RET && pcAddr == $past(instrWord[15:0], 2))
         |=> atVec || pcAddr == $past(pcAddr, 3) + 16'h1;
   endproperty
   a_stack: assert property (p_stack) else $error("bad return");
   c_call: cover property (execOk && opc == OP_CALL);
   c_wake: cover property (halted ##1 !halted);
   c_irq: cover property ($rose(irqOut));
endmodule
bind rsf_core_regs rsf_core_regs_checker #(
   .LEVEL0_VECTOR(LEVEL0_VECTOR), .LEVEL1_VECTOR(LEVEL1_VECTOR),
   .LEVEL2_VECTOR(LEVEL2_VECTOR)
) rsf_core_regs_checker_inst (
   .core_clk(core_clk), .arst_n(arst_n), .instrWord(instrWord),
   .instrValid(instrValid), .pcAddr(pcAddr), .halted(halted),
   .irqReq(irqReq), .evtReq(evtReq), .regAddr(regAddr),
   .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
   .regRdata(regRdata), .irqOut(irqOut)
);

// [sim/test_rsf_core_regs.sv]
// Self-checking bench for the core register file
module test_rsf_core_regs import rsf_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   `define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin \
      failCount++; $display("[ERR] %s exp %h got %h", n, e, s); end end
   localparam logic [15:0] VEC0 = 16'h0011;
   localparam logic [15:0] VEC1 = 16'h0022;
   localparam logic [15:0] VEC2 = 16'h0033;
   localparam logic [4:0] STATUS_ADDR = {1'b0, IDX_STATUS};
   localparam logic [4:0] ACC_ADDR = {1'b0, IDX_ACC};
   logic core_clk;
   logic arst_n = 1'b0;
   logic [21:0] instrWord = 22'h0;
   logic instrValid = 1'b0;
   logic [2:0] irqReq = 3'h0;
   logic [1:0] evtReq = 2'h0;
   logic [4:0] regAddr = 5'h00;
   logic [7:0] regWdata = 8'h00;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   wire [15:0] pcAddr;
   wire halted;
   wire [7:0] regRdata;
   wire irqOut;
   int failCount = 0;
   int compares = 0;
   rsf_op_t opTab [8] = '{OP_SHL, OP_SHR, OP_ADD, OP_ADD, OP_SUB, OP_SUB,
      OP_MUL, OP_MOVI};
   logic [7:0] dTab [8] = '{8'h00, 8'h00, 8'hff, 8'h7f, 8'h00, 8'h80,
      8'h12, 8'h00};
   logic [7:0] sTab [8] = '{8'hc1, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01,
      8'h10, 8'h00};
   logic [7:0] aTab [8] = '{8'h82, 8'h00, 8'h00, 8'h80, 8'hff, 8'h7f,
      8'h20, 8'h00};
   logic [2:0] fTab [8] = '{3'h2, 3'h3, 3'h3, 3'h4, 3'h0, 3'h6, 3'h6, 3'h7};
   logic [7:0] rTab [8] = '{8'h82, 8'h00, 8'h00, 8'h80, 8'hff, 8'h7f,
      8'h01, 8'h00};

   rsf_core_regs #(
      .LEVEL0_VECTOR(VEC0), .LEVEL1_VECTOR(VEC1), .LEVEL2_VECTOR(VEC2)
   ) rsf_core_regs_inst (
      .core_clk(core_clk), .arst_n(arst_n), .instrWord(instrWord),
      .instrValid(instrValid), .pcAddr(pcAddr), .halted(halted),
      .irqReq(irqReq), .evtReq(evtReq), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .irqOut(irqOut)
   );

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   task endSim;
      $display("Compares %0d, mismatches %0d", compares, failCount);
      if (failCount == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge core_clk);
      regWr <= 1'b0;
      #1;
   endtask

   // Read data stand only in the cycle after the strobe
   task rd(input logic [4:0] a, input logic [7:0] e);
      @(posedge core_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge core_clk);
      regRd <= 1'b0;
      #1;
      `CHK("regRdata", e, regRdata)
   endtask

   task ex(input logic [21:0] w);
      @(posedge core_clk);
      instrWord <= w;
      instrValid <= 1'b1;
      @(posedge core_clk);
      instrValid <= 1'b0;
      #1;
   endtask

   task pulse(input logic [2:0] i, input logic [1:0] e);
      @(posedge core_clk);
      irqReq <= i;
      evtReq <= e;
      @(posedge core_clk);
      irqReq <= 3'h0;
      evtReq <= 2'h0;
      #1;
   endtask

   // Either pc reaching a value or the core leaving halt
   task automatic waitFor(input bit onPc, input logic [15:0] e);
      int n = 0;
      while ((onPc ? pcAddr !== e : halted !== 1'b0) && n < 20) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      if (n == 20) begin
         failCount++;
         $display("[ERR] wait pcAddr exp %h got %h", e, pcAddr);
         endSim();
      end
   endtask

   task tRegs;
      for (int i = 0; i < 14; i++) wr(5'(i), 8'(8'h11 * i));
      for (int i = 0; i < 14; i++) rd(5'(i), 8'(8'h11 * i));
      rd(5'h1f, 8'h00);
   endtask

   task tFlow;
      wr({1'b0, IDX_PROG_IDX_HI}, 8'h01);
      wr({1'b0, IDX_PROG_IDX_LO}, 8'h20);
      ex({OP_JUMPIP, 16'h0000});
      `CHK("pcAddr", 16'h0120, pcAddr)
      rd(OFS_PC_LO, 8'h20);
      rd(OFS_PC_HI, 8'h01);
      ex({OP_CALL, 16'h0400});
      `CHK("pcAddr", 16'h0400, pcAddr)
      ex({OP_RET, 16'h0000});
      `CHK("pcAddr", 16'h0121, pcAddr)
   endtask

   task tAlu;
      for (int i = 0; i < 8; i++) begin
         wr(5'h01, dTab[i]);
         wr(5'h02, sTab[i]);
         ex({opTab[i], 4'h1, 4'h2, sTab[i]});
         rd(OFS_FLAGS, {5'h00, fTab[i]});
         rd(ACC_ADDR, aTab[i]);
         rd(5'h01, rTab[i]);
      end
   endtask

   // Conditional moves and jumps, shadow call, stack moves, core stop
   task tMisc;
      wr(5'h02, 8'h5a);
      ex({OP_CMVD, 4'h1, 4'h2, 8'h00});
      rd(5'h01, 8'h00);
      rd(ACC_ADDR, 8'h5a);
      ex({OP_CMVS, 4'h1, 4'h2, 8'h00});
      rd(5'h01, 8'h5a);
      ex({OP_JNC, 16'h0700});
      `CHK("pcAddr", 16'h012c, pcAddr)
      ex({OP_JC, 16'h0700});
      `CHK("pcAddr", 16'h0700, pcAddr)
      ex({OP_CALLS, 16'h0800});
      rd({1'b0, IDX_PROG_IDX_LO}, 8'h01);
      ex({OP_RETS, 16'h0000});
      `CHK("pcAddr", 16'h0701, pcAddr)
      ex({OP_PUSH, 16'h0000});
      wr({1'b0, IDX_PROG_IDX_LO}, 8'h00);
      ex({OP_POP, 16'h0000});
      rd({1'b0, IDX_PROG_IDX_LO}, 8'h01);
      ex({OP_POP, 16'h0000});
      rd(OFS_INT_STATUS, 8'h04);
      wr(OFS_INT_CLEAR, 8'h04);
      rd(OFS_INT_STATUS, 8'h00);
      wr(OFS_CONTROL, 8'h00);
      ex({OP_MOVI, 4'h0, 4'h0, 8'h33});
      `CHK("pcAddr", 16'h0704, pcAddr)
      rd(ACC_ADDR, 8'h5a);
      wr(OFS_CONTROL, 8'h01);
   endtask

   task tIrq;
      ex({OP_JUMP, 16'h0500});
      wr(STATUS_ADDR, 8'h20);
      pulse(3'b100, 2'b00);
      rd(STATUS_ADDR, 8'h30);
      `CHK("pcAddr", 16'h0500, pcAddr)
      wr(STATUS_ADDR, 8'h20);
      pulse(3'b010, 2'b00);
      rd(STATUS_ADDR, 8'h28);
      wr(OFS_INT_ENABLE, 8'h01);
      wr(STATUS_ADDR, 8'h68);
      waitFor(1'b1, VEC1);
      `CHK("irqOut", 1'b1, irqOut)
      rd(STATUS_ADDR, 8'h48);
      wr(STATUS_ADDR, 8'h40);
      ex({OP_RETI, 16'h0000});
      `CHK("pcAddr", 16'h0500, pcAddr)
      rd(STATUS_ADDR, 8'h60);
      rd(OFS_INT_STATUS, 8'h01);
      wr(OFS_INT_ENABLE, 8'h00);
      `CHK("irqOut", 1'b0, irqOut)
      wr(OFS_INT_CLEAR, 8'h01);
      wr(OFS_INT_ENABLE, 8'h01);
      `CHK("irqOut", 1'b0, irqOut)
   endtask

   task tHalt;
      ex({OP_HALT, 16'h0000});
      repeat (3) @(posedge core_clk);
      #1;
      `CHK("halted", 1'b1, halted)
      `CHK("pcAddr", 16'h0501, pcAddr)
      pulse(3'b000, 2'b10);
      waitFor(1'b0, 16'h0000);
      `CHK("pcAddr", 16'h0501, pcAddr)
      rd(STATUS_ADDR, 8'h62);
      wr(STATUS_ADDR, 8'h20);
      ex({OP_HALT, 16'h0000});
      pulse(3'b001, 2'b00);
      waitFor(1'b1, VEC0);
      `CHK("halted", 1'b0, halted)
      rd(STATUS_ADDR, 8'h04);
      pulse(3'b000, 2'b01);
      rd(STATUS_ADDR, 8'h05);
   endtask

   initial begin
      repeat (2) @(posedge core_clk);
      arst_n <= 1'b1;
      rd(STATUS_ADDR, STATUS_RESET);
      tRegs();
      tFlow();
      tAlu();
      tMisc();
      tIrq();
      tHalt();
      endSim();
   end
endmodule
